// ### src/uart_frame_ctrl.sv
// serial port frame control, transmit empty flag and transmitter with axi4-lite registers
// assumes an external pull-up holds floating pins high; rx side flags are reset-only here
//
// Function
// - empty flag sets when shifter takes data
// - status read then data write clears flag
// - transmitter enable sets the empty flag
// - master off leaves both pins undriven
// - master on: pins follow mode and enables
// - disable flushes buffer, resets baud counter
// - disable clears enables, flags; sets idle flags
// - disable keeps other configuration bits intact
// - clearing master aborts frames, keeps configuration
// - nine bit select picks 8 or 9 bits
// - parity replaces last data bit
// - parity enable turns parity on
// - parity type: one odd, zero even
// - two stop select gives two stops
// - received ninth bit is read only
// - transmit ninth bit is write only
// - transmitter needs both enables; abort otherwise
// - empty flag with enable raises request
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module uart_frame_ctrl
   import uart_frame_pkg::*;
#(
   parameter int unsigned BAUD_WIDTH = 8
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic tx_pin_out,
   output logic tx_pin_oe_out,
   output logic shared_rx_tx_pin_out,
   output logic shared_rx_tx_pin_oe_out,
   output logic port_irq_out
);
   import uart_frame_pkg::*;

   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK} tx_state_t;

   // bus slave state
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic w_lane_reg, w_lane_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   // registers
   frame_cfg_t cfg_reg, cfg_next;
   logic tx_empty_ie_reg, tx_empty_ie_next;
   logic [4:0] ec_misc_reg, ec_misc_next;
   logic [7:0] baud_reg, baud_next;
   logic [7:0] hold_data_reg, hold_data_next;
   logic hold_ninth_reg, hold_ninth_next;
   logic hold_full_reg, hold_full_next;
   logic empty_flag_reg, empty_flag_next;
   logic status_armed_reg, status_armed_next;
   logic rx_ninth_reg;
   // transmitter
   tx_state_t tx_state_reg, tx_state_next;
   logic [8:0] shift_reg, shift_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [4:0] brk_cnt_reg, brk_cnt_next;
   logic [BAUD_WIDTH+3:0] baud_cnt_reg, baud_cnt_next;
   logic parity_reg, parity_next;
   logic line_reg, line_next;
   pin_drive_t pins;

   logic wr_fire, rd_fire, tx_run, bit_tick, status_hit, port_active;
   logic [BAUD_WIDTH+3:0] bit_period;

   assign port_active = cfg_reg.master_enable;
   assign tx_run = cfg_reg.master_enable && cfg_reg.tx_enable_bit;
   // a bit lasts 16 * (divisor + 1) clocks
   assign bit_period = {baud_reg, 4'hf};
   assign bit_tick = tx_run && (baud_cnt_reg == bit_period);
   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign rd_fire = s_axi_arvalid_in && !rvalid_reg;
   assign status_hit = rd_fire && s_axi_araddr_in == PORT_STATUS_ADDR;

   assign s_axi_awready_out = !aw_hold_reg;
   assign s_axi_wready_out = !w_hold_reg;
   assign s_axi_arready_out = !rvalid_reg;
   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out = bresp_reg;
   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rresp_out = rresp_reg;
   assign s_axi_rdata_out = rdata_reg;
   assign port_irq_out = tx_empty_ie_reg && empty_flag_reg && port_active;

   // the receiver is outside this block, so the received ninth bit stays at reset
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rx_ninth_reg <= 1'b0;
      end else begin
         rx_ninth_reg <= rx_ninth_reg;
      end
   end

   // bus slave and register file
   always_comb begin
      logic [7:0] wb;
      wb = w_data_reg[7:0];
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      w_data_next = w_data_reg;
      w_lane_next = w_lane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      cfg_next = cfg_reg;
      tx_empty_ie_next = tx_empty_ie_reg;
      ec_misc_next = ec_misc_reg;
      baud_next = baud_reg;
      hold_data_next = hold_data_reg;
      hold_ninth_next = hold_ninth_reg;
      hold_full_next = hold_full_reg;
      empty_flag_next = empty_flag_reg;
      status_armed_next = status_armed_reg;
      if (s_axi_awvalid_in && !aw_hold_reg) begin
         aw_hold_next = 1'b1;
         aw_addr_next = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_hold_reg) begin
         w_hold_next = 1'b1;
         w_data_next = s_axi_wdata_in;
         w_lane_next = s_axi_wstrb_in[0];
      end
      if (bvalid_reg && s_axi_bready_in) begin
         bvalid_next = 1'b0;
      end
      if (rvalid_reg && s_axi_rready_in) begin
         rvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         if (w_lane_reg) begin
            unique case (aw_addr_reg)
               FRAME_CONTROL_ADDR: begin
                  cfg_next.master_enable = wb[FC_MASTER];
                  cfg_next.nine_bit_select = wb[FC_NINE];
                  cfg_next.parity_enable_bit = wb[FC_PAR_EN];
                  cfg_next.parity_odd_select = wb[FC_PAR_ODD];
                  cfg_next.two_stop_select = wb[FC_TWO_STOP];
                  cfg_next.break_send_bit = wb[FC_BREAK];
                  hold_ninth_next = wb[FC_TX8];
               end
               ENABLE_CONTROL_ADDR: begin
                  cfg_next.tx_enable_bit = wb[EC_TX_EN];
                  cfg_next.rx_enable_bit = wb[EC_RX_EN];
                  tx_empty_ie_next = wb[EC_TX_EMPTY_IE];
                  ec_misc_next = wb[EC_RX_EN-1:EC_TX_EMPTY_IE+1];
                  if (wb[EC_TX_EN] && !cfg_reg.tx_enable_bit) begin
                     empty_flag_next = 1'b1;
                  end
               end
               WIRE_MODE_ADDR: cfg_next.single_wire_select = wb[0];
               BAUD_DIVISOR_ADDR: baud_next = wb;
               PORT_DATA_ADDR: begin
                  hold_data_next = wb;
                  hold_full_next = 1'b1;
                  if (status_armed_reg) begin
                     empty_flag_next = 1'b0;
                     status_armed_next = 1'b0;
                  end
               end
               PORT_STATUS_ADDR: ;
               default: bresp_next = RESP_SLVERR;
            endcase
         end
      end
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = '0;
         unique case (s_axi_araddr_in)
            FRAME_CONTROL_ADDR: begin
               rdata_next[FC_MASTER] = cfg_reg.master_enable;
               rdata_next[FC_NINE] = cfg_reg.nine_bit_select;
               rdata_next[FC_PAR_EN] = cfg_reg.parity_enable_bit;
               rdata_next[FC_PAR_ODD] = cfg_reg.parity_odd_select;
               rdata_next[FC_TWO_STOP] = cfg_reg.two_stop_select;
               rdata_next[FC_BREAK] = cfg_reg.break_send_bit;
               rdata_next[FC_RX8] = rx_ninth_reg;
            end
            ENABLE_CONTROL_ADDR: begin
               rdata_next[EC_TX_EN] = cfg_reg.tx_enable_bit;
               rdata_next[EC_RX_EN] = cfg_reg.rx_enable_bit;
               rdata_next[EC_RX_EN-1:EC_TX_EMPTY_IE+1] = ec_misc_reg;
               rdata_next[EC_TX_EMPTY_IE] = tx_empty_ie_reg;
            end
            WIRE_MODE_ADDR: rdata_next[0] = cfg_reg.single_wire_select;
            BAUD_DIVISOR_ADDR: rdata_next[7:0] = baud_reg;
            PORT_STATUS_ADDR: begin
               rdata_next[ST_RX_IDLE] = 1'b1;
               rdata_next[ST_TX_IDLE] = !hold_full_reg && tx_state_reg == TX_IDLE && !cfg_reg.break_send_bit;
               rdata_next[ST_TX_EMPTY] = empty_flag_reg;
            end
            PORT_DATA_ADDR: ;
            default: rresp_next = RESP_SLVERR;
         endcase
      end
      if (status_hit && empty_flag_reg) begin
         status_armed_next = 1'b1;
      end
      // shifter takes the held character
      if (tx_run && tx_state_reg == TX_IDLE && hold_full_reg) begin
         hold_full_next = wr_fire && w_lane_reg && aw_addr_reg == PORT_DATA_ADDR;
         empty_flag_next = 1'b1;
      end
      if (port_active && !cfg_reg.tx_enable_bit) begin
         hold_full_next = 1'b0;
      end
      // master off: reset activity and flags, keep configuration
      if (!cfg_reg.master_enable) begin
         cfg_next.tx_enable_bit = 1'b0;
         cfg_next.rx_enable_bit = 1'b0;
         cfg_next.break_send_bit = 1'b0;
         hold_full_next = 1'b0;
         empty_flag_next = 1'b1;
         status_armed_next = 1'b0;
      end
   end

   // transmitter next state
   always_comb begin
      tx_state_next = tx_state_reg;
      shift_next = shift_reg;
      bit_cnt_next = bit_cnt_reg;
      brk_cnt_next = brk_cnt_reg;
      parity_next = parity_reg;
      line_next = line_reg;
      baud_cnt_next = bit_tick ? '0 : baud_cnt_reg + 1'b1;
      unique case (tx_state_reg)
         TX_IDLE: begin
            line_next = 1'b1;
            baud_cnt_next = '0;
            if (tx_run && hold_full_reg) begin
               tx_state_next = TX_START;
               shift_next = {hold_ninth_reg, hold_data_reg};
               parity_next = cfg_reg.parity_odd_select;
               line_next = 1'b0;
            end else if (tx_run && cfg_reg.break_send_bit) begin
               tx_state_next = TX_BREAK;
               brk_cnt_next = '0;
               line_next = 1'b0;
            end
         end
         TX_START: begin
            if (bit_tick) begin
               tx_state_next = TX_DATA;
               bit_cnt_next = '0;
               line_next = shift_reg[0];
               parity_next = parity_reg ^ shift_reg[0];
               shift_next = shift_reg >> 1;
            end
         end
         TX_DATA: begin
            if (bit_tick) begin
               // parity takes the place of the last data bit
               if (bit_cnt_reg == (cfg_reg.nine_bit_select ? 4'd7 : 4'd6) - {3'b000, cfg_reg.parity_enable_bit} + 4'd1
                   && cfg_reg.parity_enable_bit) begin
                  tx_state_next = TX_PARITY;
                  line_next = parity_reg;
               end else if (bit_cnt_reg == (cfg_reg.nine_bit_select ? 4'd8 : 4'd7)) begin
                  tx_state_next = TX_STOP;
                  bit_cnt_next = '0;
                  line_next = 1'b1;
               end else begin
                  bit_cnt_next = bit_cnt_reg + 1'b1;
                  line_next = shift_reg[0];
                  parity_next = parity_reg ^ shift_reg[0];
                  shift_next = shift_reg >> 1;
               end
            end
         end
         TX_PARITY: begin
            if (bit_tick) begin
               tx_state_next = TX_STOP;
               bit_cnt_next = '0;
               line_next = 1'b1;
            end
         end
         TX_STOP: begin
            if (bit_tick) begin
               if (cfg_reg.two_stop_select && bit_cnt_reg == '0) begin
                  bit_cnt_next = 4'd1;
               end else begin
                  tx_state_next = TX_IDLE;
               end
            end
         end
         TX_BREAK: begin
            line_next = 1'b0;
            if (bit_tick && brk_cnt_reg != 5'(BREAK_BITS)) begin
               brk_cnt_next = brk_cnt_reg + 1'b1;
            end
            if (brk_cnt_reg == 5'(BREAK_BITS) && !cfg_reg.break_send_bit) begin
               tx_state_next = TX_IDLE;
               line_next = 1'b1;
            end
         end
      endcase
      if (!tx_run) begin
         tx_state_next = TX_IDLE;
         baud_cnt_next = '0;
         line_next = 1'b1;
      end
   end

   // pin drive: single wire mode sends on the shared pin unless receive is also on
   always_comb begin
      pins.tx_drive = line_reg;
      pins.shared_drive = line_reg;
      pins.tx_drive_en = 1'b0;
      pins.shared_drive_en = 1'b0;
      if (cfg_reg.master_enable) begin
         if (cfg_reg.single_wire_select) begin
            pins.shared_drive_en = cfg_reg.tx_enable_bit && !cfg_reg.rx_enable_bit;
         end else begin
            pins.tx_drive_en = cfg_reg.tx_enable_bit;
         end
      end
   end
   assign tx_pin_out = pins.tx_drive;
   assign tx_pin_oe_out = pins.tx_drive_en;
   assign shared_rx_tx_pin_out = pins.shared_drive;
   assign shared_rx_tx_pin_oe_out = pins.shared_drive_en;

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
         cfg_reg <= '0;
         tx_empty_ie_reg <= 1'b0;
         ec_misc_reg <= '0;
         baud_reg <= BAUD_RESET;
         hold_data_reg <= '0;
         hold_ninth_reg <= 1'b0;
         hold_full_reg <= 1'b0;
         empty_flag_reg <= 1'b1;
         status_armed_reg <= 1'b0;
         tx_state_reg <= TX_IDLE;
         shift_reg <= '0;
         bit_cnt_reg <= '0;
         brk_cnt_reg <= '0;
         baud_cnt_reg <= '0;
         parity_reg <= 1'b0;
         line_reg <= 1'b1;
      end else begin
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         w_data_reg <= w_data_next;
         w_lane_reg <= w_lane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         cfg_reg <= cfg_next;
         tx_empty_ie_reg <= tx_empty_ie_next;
         ec_misc_reg <= ec_misc_next;
         baud_reg <= baud_next;
         hold_data_reg <= hold_data_next;
         hold_ninth_reg <= hold_ninth_next;
         hold_full_reg <= hold_full_next;
         empty_flag_reg <= empty_flag_next;
         status_armed_reg <= status_armed_next;
         tx_state_reg <= tx_state_next;
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
         brk_cnt_reg <= brk_cnt_next;
         baud_cnt_reg <= baud_cnt_next;
         parity_reg <= parity_next;
         line_reg <= line_next;
      end
   end
endmodule
`default_nettype wire

// ### src/uart_frame_pkg.sv
// constants, register map and carrier types for the serial port frame control block
// assumes a 32-bit axi4-lite register bus and one 200 mhz clock
`default_nettype none
package uart_frame_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned BREAK_BITS = 13;
   // register byte addresses
   localparam logic [7:0] FRAME_CONTROL_ADDR = 8'h00;
   localparam logic [7:0] ENABLE_CONTROL_ADDR = 8'h04;
   localparam logic [7:0] WIRE_MODE_ADDR = 8'h08;
   localparam logic [7:0] PORT_STATUS_ADDR = 8'h0c;
   localparam logic [7:0] PORT_DATA_ADDR = 8'h10;
   localparam logic [7:0] BAUD_DIVISOR_ADDR = 8'h14;
   // frame_control_reg fields
   localparam int FC_MASTER = 7;
   localparam int FC_NINE = 6;
   localparam int FC_PAR_EN = 5;
   localparam int FC_PAR_ODD = 4;
   localparam int FC_TWO_STOP = 3;
   localparam int FC_BREAK = 2;
   localparam int FC_RX8 = 1;
   localparam int FC_TX8 = 0;
   // enable_control_reg fields
   localparam int EC_TX_EN = 7;
   localparam int EC_RX_EN = 6;
   localparam int EC_TX_EMPTY_IE = 0;
   // port_status_reg fields
   localparam int ST_OVERRUN = 7;
   localparam int ST_FRAMING = 6;
   localparam int ST_PARITY = 5;
   localparam int ST_NOISE = 4;
   localparam int ST_RX_IDLE = 3;
   localparam int ST_RX_AVAIL = 2;
   localparam int ST_TX_IDLE = 1;
   localparam int ST_TX_EMPTY = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic master_enable;
      logic nine_bit_select;
      logic parity_enable_bit;
      logic parity_odd_select;
      logic two_stop_select;
      logic break_send_bit;
      logic tx_enable_bit;
      logic rx_enable_bit;
      logic single_wire_select;
   } frame_cfg_t;

   typedef struct packed {
      logic tx_drive;
      logic tx_drive_en;
      logic shared_drive;
      logic shared_drive_en;
   } pin_drive_t;
endpackage
`default_nettype wire

// ### verification/serial_listener.sv
// remote receiver on the transmit line, sampling each bit at its middle
// assumes the bench gives bit time in clocks and frame length in bits
`default_nettype none
module serial_listener (
   input wire logic clk_in,
   input wire logic line_in,
   input wire logic [15:0] bit_clks_in,
   input wire logic [3:0] nbits_in,
   output logic [11:0] frame_out,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_out = 12'h000;
      done_out = 1'b0;
      forever begin
         @(negedge line_in);
         repeat (bit_clks_in / 2) @(posedge clk_in);
         for (int i = 0; i < nbits_in; i++) begin
            frame_out[i] <= line_in;
            if (i + 1 < nbits_in) repeat (bit_clks_in) @(posedge clk_in);
         end
         done_out <= 1'b1;
         @(posedge clk_in);
         done_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench: register map, frame formats, break, wire modes, disable and resume
// assumes a pull-up on the transmit line and bus readies held by the bench
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_frame_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] aw_a = 8'h00;
   logic [7:0] ar_a = 8'h00;
   logic [31:0] w_d = 32'h00000000;
   logic aw_v = 1'b0;
   logic w_v = 1'b0;
   logic ar_v = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx, tx_oe, sh, sh_oe, irq, done, line;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] frame;
   logic [15:0] bit_clks = 16'h0010;
   logic [3:0] nb = 4'ha;
   logic [31:0] seed = 32'h0000e2e7;
   int n_errors = 0;
   int samples_checked = 0;
   assign line = tx_oe ? tx : 1'b1;
   always #2.5 clk = !clk;
   uart_frame_ctrl dut_u (.ref_clk_in(clk), .reset_in(rst), .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
      .s_axi_awready_out(awready), .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(w_v),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
      .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1), .tx_pin_out(tx),
      .tx_pin_oe_out(tx_oe), .shared_rx_tx_pin_out(sh), .shared_rx_tx_pin_oe_out(sh_oe), .port_irq_out(irq));
   serial_listener rx_u (.clk_in(clk), .line_in(line), .bit_clks_in(bit_clks), .nbits_in(nb), .frame_out(frame),
      .done_out(done));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] exp_frame(input logic [7:0] c, input logic [8:0] v);
      int n;
      logic [11:0] f;
      n = c[FC_NINE] ? 9 : 8;
      if (c[FC_PAR_EN]) v[n-1] = c[FC_PAR_ODD] ^ (^(v & ((9'h001 << (n - 1)) - 9'h001)));
      f = 12'hffe;
      for (int i = 0; i < n; i++) f[i+1] = v[i];
      return f;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      aw_a <= a;
      w_d <= {24'h000000, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_v && awready) aw_v <= 1'b0;
         if (w_v && wready) w_v <= 1'b0;
      end while (!bvalid);
      chk(bresp, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
      ar_a <= a;
      ar_v <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_v && arready) ar_v <= 1'b0;
      end while (!rvalid);
      chk({rresp, rdata}, {er, 24'h000000, e});
   endtask
   task automatic wait_frame(input logic [7:0] c, input logic [8:0] v);
      int t;
      logic [11:0] m;
      t = 0;
      m = (12'h001 << nb) - 12'h001;
      do begin
         @(posedge clk);
         t++;
      end while (!done && t < 1000);
      chk({done, frame & m}, {1'b1, exp_frame(c, v) & m});
   endtask
   task automatic send_pair(input logic [7:0] c, input logic t8);
      logic [7:0] d1, d2;
      d1 = rnd();
      d2 = rnd();
      nb <= 4'ha + c[FC_NINE] + c[FC_TWO_STOP];
      rdc(PORT_STATUS_ADDR, 8'h0b);
      wr(PORT_DATA_ADDR, d1);
      rdc(PORT_STATUS_ADDR, 8'h09);
      wr(PORT_DATA_ADDR, d2);
      rdc(PORT_STATUS_ADDR, 8'h08);
      chk(irq, 1'b0);
      wait_frame(c, {t8, d1});
      wait_frame(c, {t8, d2});
      repeat (2 * bit_clks) @(posedge clk);
   endtask
   initial begin
      logic [7:0] c;
      logic t8;
      int lo;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rdc(FRAME_CONTROL_ADDR, 8'h00);
      rdc(PORT_STATUS_ADDR, 8'h0b);
      rdc(8'h18, 8'h00, RESP_SLVERR);
      wr(8'h18, 8'hff, RESP_SLVERR);
      $display("test reset_and_map done");
      for (int k = 0; k < 16; k++) begin
         c = {1'b1, k[3:0], 3'b000};
         t8 = rnd() > 32'h7fffffff;
         wr(FRAME_CONTROL_ADDR, c | {7'h00, t8});
         rdc(FRAME_CONTROL_ADDR, c);
         if (k == 0) wr(ENABLE_CONTROL_ADDR, 8'h81);
         if (k == 0) chk(irq, 1'b1);
         send_pair(c, t8);
      end
      $display("test frame_formats done");
      wr(FRAME_CONTROL_ADDR, 8'h84);
      for (lo = 0; line && lo < 500; lo++) @(posedge clk);
      lo = 0;
      repeat (BREAK_BITS * 16) begin
         @(posedge clk);
         lo += !line;
      end
      chk(lo, BREAK_BITS * 16);
      wr(FRAME_CONTROL_ADDR, 8'h80);
      for (lo = 0; !line && lo < 300; lo++) @(posedge clk);
      chk(line, 1'b1);
      wr(WIRE_MODE_ADDR, 8'h01);
      chk({tx_oe, sh_oe}, 2'b01);
      wr(ENABLE_CONTROL_ADDR, 8'hc1);
      chk({tx_oe, sh_oe}, 2'b00);
      wr(WIRE_MODE_ADDR, 8'h00);
      chk({tx_oe, sh_oe}, 2'b10);
      $display("test break_and_wires done");
      wr(BAUD_DIVISOR_ADDR, 8'h01);
      wr(PORT_DATA_ADDR, 8'h5a);
      repeat (40) @(posedge clk);
      wr(FRAME_CONTROL_ADDR, 8'h3c);
      chk({tx_oe, sh_oe}, 2'b00);
      rdc(FRAME_CONTROL_ADDR, 8'h38);
      rdc(ENABLE_CONTROL_ADDR, 8'h01);
      rdc(PORT_STATUS_ADDR, 8'h0b);
      rdc(BAUD_DIVISOR_ADDR, 8'h01);
      repeat (600) @(posedge clk);
      bit_clks <= 16'h0020;
      wr(FRAME_CONTROL_ADDR, 8'hb8);
      wr(ENABLE_CONTROL_ADDR, 8'h81);
      chk(irq, 1'b1);
      send_pair(8'hb8, 1'b0);
      wr(PORT_DATA_ADDR, 8'ha5);
      repeat (40) @(posedge clk);
      wr(ENABLE_CONTROL_ADDR, 8'h01);
      chk(tx_oe, 1'b0);
      $display("test disable_and_resume done");
      give_verdict();
   end
   // roughly five times the expected run
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
endmodule
`default_nettype wire

// ### verification/uart_frame_ctrl_asserts.sv
// port-level assertions for uart_frame_ctrl
// assumes a write lands at the edge after both its address and its data are held
`default_nettype none
module uart_frame_ctrl_checker
   import uart_frame_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic tx_pin_out,
   input wire logic tx_pin_oe_out,
   input wire logic shared_rx_tx_pin_out,
   input wire logic shared_rx_tx_pin_oe_out,
   input wire logic port_irq_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   logic s_q, wr_now, fc_wr, ec_wr, master_reg, ie_reg, txen_reg;
   logic [7:0] a_q, d_q;
   assign wr_now = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
   assign fc_wr = wr_now && s_q && a_q == FRAME_CONTROL_ADDR;
   assign ec_wr = wr_now && s_q && a_q == ENABLE_CONTROL_ADDR;
   // shadow of the enables, in step with the block
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         master_reg <= 1'b0;
         ie_reg <= 1'b0;
         txen_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) a_q <= s_axi_awaddr_in;
         if (s_axi_wvalid_in && s_axi_wready_out) d_q <= s_axi_wdata_in[7:0];
         if (s_axi_wvalid_in && s_axi_wready_out) s_q <= s_axi_wstrb_in[0];
         if (fc_wr) master_reg <= d_q[FC_MASTER];
         if (ec_wr) ie_reg <= d_q[EC_TX_EMPTY_IE];
         if (ec_wr) txen_reg <= d_q[EC_TX_EN] && master_reg;
         if (fc_wr && !d_q[FC_MASTER]) txen_reg <= 1'b0;
      end
   end
   property p_off_floats;
      !master_reg |-> !tx_pin_oe_out && !shared_rx_tx_pin_oe_out;
   endproperty
   a_off_floats: assert property (p_off_floats) else $error("pin driven while off");
   property p_irq_gate;
      !(master_reg && ie_reg) |-> !port_irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
   property p_enable_sets_empty;
      $rose(txen_reg) && ie_reg |-> port_irq_out;
   endproperty
   a_enable_sets_empty: assert property (p_enable_sets_empty) else $error("empty flag not set");
   property p_txen_off;
      !txen_reg |-> !tx_pin_oe_out && !shared_rx_tx_pin_oe_out;
   endproperty
   a_txen_off: assert property (p_txen_off) else $error("driven without tx enable");
   property p_one_driver;
      !(tx_pin_oe_out && shared_rx_tx_pin_oe_out) && (tx_pin_out == shared_rx_tx_pin_out);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("both pins driven");
   property p_write_answer;
      wr_now |=> s_axi_bvalid_out;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_slverr;
      wr_now && s_q && a_q > BAUD_DIVISOR_ADDR |=> s_axi_bresp_out == RESP_SLVERR;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped write accepted");
   property p_read_answer;
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read response");
endmodule
bind uart_frame_ctrl uart_frame_ctrl_checker chk_u (.ref_clk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
   .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
   .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .tx_pin_out, .tx_pin_oe_out,
   .shared_rx_tx_pin_out, .shared_rx_tx_pin_oe_out, .port_irq_out);
`default_nettype wire
